// File: logic/ssb_pkg.sv
// Contract
// - acc gets acc minus mem minus not-carry, flags
// - carry cleared if negative, set otherwise
// - memory variant writes same difference back
// - decrement memory, store, skip if zero
// - skip inserts dummy cycle, two cycles total
// - acc variant writes acc, memory untouched
// - nonzero result continues without dummy cycle
// - set-byte writes all ones to memory
package ssb_pkg;

  // ----------------------------------------
  // operations and carriers
  // ----------------------------------------
  localparam int DATA_W = 8;

  typedef enum logic [4:0] {
    SSB_OP_NONE    = 5'h00,
    SSB_OP_SUB_ACC = 5'h01,
    SSB_OP_SUB_MEM = 5'h02,
    SSB_OP_DSZ_MEM = 5'h04,
    SSB_OP_DSZ_ACC = 5'h08,
    SSB_OP_SET     = 5'h10
  } ssb_op_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } ssb_flags_t;

  typedef struct packed {
    logic       valid;
    ssb_op_t    op;
    logic [7:0] acc;
    logic [7:0] mem;
    ssb_flags_t flags;
  } ssb_req_t;

  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc;
    logic       mem_we;
    logic [7:0] mem;
    logic       flags_we;
    ssb_flags_t flags;
    logic       skip;
  } ssb_res_t;

  localparam logic [7:0] SSB_ALL_ONES  = 8'hFF;
  localparam logic [7:0] SSB_DEC_STEP  = 8'h01;
  localparam int         SSB_SKIP_CYCS = 2;

endpackage

// File: logic/ssb_datapath.sv
`timescale 1ns/1ps
module ssb_datapath
  import ssb_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire ssb_req_t req,
  output ssb_res_t      res_reg,
  output logic          dummy_reg,
  output logic          busy_reg
);

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] dec;
  logic       borrow_in;
  ssb_flags_t sub_flags;
  ssb_res_t   res_next;
  logic       dummy_next;
  logic       busy_next;
  logic [1:0] busy_run_reg;
  logic [1:0] busy_run_next;

  // one nine-bit subtractor serves both destinations; bit 8 is the borrow
  always_comb begin
    borrow_in = ~req.flags.carry_flag;
    diff      = {1'b0, req.acc} - {1'b0, req.mem}
                - {8'h00, borrow_in};
    low_diff  = {1'b0, req.acc[3:0]} - {1'b0, req.mem[3:0]}
                - {4'h0, borrow_in};
    dec       = req.mem - SSB_DEC_STEP;
    sub_flags.carry_flag     = ~diff[8];
    sub_flags.aux_carry_flag = ~low_diff[4];
    sub_flags.zero_flag      = (diff[7:0] == 8'h00);
    // signed overflow: operands differ in sign and result sign flips
    sub_flags.overflow_flag  = (req.acc[7] != req.mem[7]) &&
                               (diff[7] != req.acc[7]);
  end

  // ----------------------------------------
  // result and skip sequencing
  // ----------------------------------------
  always_comb begin
    res_next   = '0;
    res_next.flags = req.flags;
    dummy_next = 1'b0;
    busy_next  = 1'b0;
    // a request during the dummy slot is the skipped one and is dropped
    if (req.valid && !busy_reg) begin
      unique case (req.op)
        SSB_OP_SUB_ACC: begin
          res_next.acc_we   = 1'b1;
          res_next.acc      = diff[7:0];
          res_next.flags_we = 1'b1;
          res_next.flags    = sub_flags;
        end
        SSB_OP_SUB_MEM: begin
          res_next.mem_we   = 1'b1;
          res_next.mem      = diff[7:0];
          res_next.flags_we = 1'b1;
          res_next.flags    = sub_flags;
        end
        SSB_OP_DSZ_MEM: begin
          res_next.mem_we = 1'b1;
          res_next.mem    = dec;
          res_next.skip   = (dec == 8'h00);
        end
        SSB_OP_DSZ_ACC: begin
          res_next.acc_we = 1'b1;
          res_next.acc    = dec;
          res_next.skip   = (dec == 8'h00);
        end
        SSB_OP_SET: begin
          res_next.mem_we = 1'b1;
          res_next.mem    = SSB_ALL_ONES;
        end
        default: ;
      endcase
      busy_next = res_next.skip;
    end else if (busy_reg) begin
      dummy_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_reg   <= '0;
      dummy_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (ce) begin
      res_reg   <= res_next;
      dummy_reg <= dummy_next;
      busy_reg  <= busy_next;
    end
  end

  // ----------------------------------------
  // skip span watch
  // ----------------------------------------
  // counts consecutive busy slots so a stuck busy cannot hide behind
  // a long run of dropped requests; frozen with the rest by ce
  always_comb begin
    busy_run_next = busy_next ? busy_run_reg + 2'h1 : 2'h0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_run_reg <= 2'h0;
    end else if (ce) begin
      busy_run_reg <= busy_run_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // the borrow is widened by concatenation so it is never inverted wide
  a_sub_acc_value: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_SUB_ACC |=> res_reg.acc_we &&
    res_reg.acc == 8'($past(req.acc) - $past(req.mem)
    - {7'h00, ~$past(req.flags.carry_flag)}))
    else $error("acc subtract result wrong");
  a_sub_carry: assert property (ce && req.valid && !busy_reg &&
    (req.op == SSB_OP_SUB_ACC || req.op == SSB_OP_SUB_MEM) |=>
    res_reg.flags.carry_flag == ({1'b0, $past(req.acc)} >=
    ({1'b0, $past(req.mem)}
    + {8'h00, ~$past(req.flags.carry_flag)})))
    else $error("carry after subtract wrong");
  a_sub_mem_value: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_SUB_MEM |=> res_reg.mem_we && !res_reg.acc_we &&
    res_reg.flags_we)
    else $error("memory subtract write missing");
  a_sub_mem_data: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_SUB_MEM |=>
    res_reg.mem == 8'($past(req.acc) - $past(req.mem)
    - {7'h00, ~$past(req.flags.carry_flag)}))
    else $error("memory subtract result wrong");
  a_sub_zero: assert property (ce && req.valid && !busy_reg &&
    (req.op == SSB_OP_SUB_ACC || req.op == SSB_OP_SUB_MEM) |=>
    res_reg.flags.zero_flag ==
    ((res_reg.acc_we ? res_reg.acc : res_reg.mem) == 8'h00))
    else $error("zero flag after subtract wrong");
  a_dec_mem: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_DSZ_MEM |=> res_reg.mem_we &&
    res_reg.mem == 8'($past(req.mem) - 8'h01) &&
    res_reg.skip == ($past(req.mem) == 8'h01))
    else $error("decrement to memory wrong");
  a_skip_dummy: assert property (res_reg.skip && ce |=>
    dummy_reg && !res_reg.acc_we && !res_reg.mem_we)
    else $error("skip without dummy cycle");
  a_dec_acc: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_DSZ_ACC |=> res_reg.acc_we && !res_reg.mem_we)
    else $error("acc decrement touched memory");
  a_dec_acc_value: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_DSZ_ACC |=>
    res_reg.acc == 8'($past(req.mem) - 8'h01) &&
    res_reg.skip == ($past(req.mem) == 8'h01))
    else $error("decrement to acc wrong");
  // the request offered in the dummy slot is the skipped one
  a_dummy_drop: assert property (busy_reg && ce |=> dummy_reg &&
    !res_reg.acc_we && !res_reg.mem_we && !res_reg.flags_we &&
    !busy_reg)
    else $error("skipped request was executed");
  a_busy_span: assert property (busy_run_reg <=
    SSB_SKIP_CYCS - 1)
    else $error("skip held busy too long");
  a_ce_freeze: assert property (!ce |=> $stable(res_reg) &&
    $stable(dummy_reg) && $stable(busy_reg))
    else $error("state moved while clock enable low");
  a_no_skip: assert property (ce && !busy_reg && !res_next.skip
    |=> !dummy_reg)
    else $error("dummy cycle without skip");
  a_set_byte: assert property (ce && req.valid && !busy_reg &&
    req.op == SSB_OP_SET |=> res_reg.mem_we &&
    res_reg.mem == 8'hFF)
    else $error("set byte not all ones");
  a_flags_kept: assert property (ce && req.valid && !busy_reg &&
    (req.op == SSB_OP_DSZ_MEM || req.op == SSB_OP_DSZ_ACC ||
    req.op == SSB_OP_SET) |=> !res_reg.flags_we)
    else $error("flags changed");
  a_one_cycle: assert property (ce && req.valid && !busy_reg &&
    !res_next.skip |=> !busy_reg)
    else $error("non-skip took extra cycle");

  c_sub_borrow: cover property (res_reg.flags_we &&
    !res_reg.flags.carry_flag);
  c_dec_skip: cover property (res_reg.skip ##1 dummy_reg);
  c_set: cover property (res_reg.mem_we && res_reg.mem == 8'hFF);
  c_dec_noskip: cover property (res_reg.mem_we && !res_reg.skip &&
    !res_reg.flags_we);
  c_freeze_skip: cover property (busy_reg && !ce ##1 busy_reg && ce);

endmodule // ssb_datapath

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssb_pkg::*;
  // ----------------------------------------
  // stimulus and reference
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b0;
  ssb_req_t    req = '0;
  ssb_res_t    res_reg;
  ssb_res_t    exp_res = '0;
  logic        dummy_reg;
  logic        busy_reg;
  logic        exp_dummy = 1'b0;
  logic        exp_busy = 1'b0;
  logic [31:0] lfsr = 32'h50850E54;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  ssb_op_t     ops [6] = '{SSB_OP_NONE, SSB_OP_SUB_ACC, SSB_OP_SUB_MEM,
                           SSB_OP_DSZ_MEM, SSB_OP_DSZ_ACC, SSB_OP_SET};

  ssb_datapath u_dut (.clk(clk), .rst(rst), .ce(ce), .req(req),
    .res_reg(res_reg), .dummy_reg(dummy_reg), .busy_reg(busy_reg));

  always #2 clk = ~clk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic ssb_res_t model(input ssb_req_t r);
    ssb_res_t m;
    int       bin;
    int       sd;
    m = '0;
    m.flags = r.flags;
    bin = r.flags.carry_flag ? 0 : 1;
    sd = $signed(r.acc) - $signed(r.mem) - bin;
    if (r.op == SSB_OP_SUB_ACC || r.op == SSB_OP_SUB_MEM) begin
      m.acc_we = (r.op == SSB_OP_SUB_ACC);
      m.mem_we = ~m.acc_we;
      m.acc = 8'(int'(r.acc) - int'(r.mem) - bin);
      m.mem = m.acc;
      m.flags_we = 1'b1;
      m.flags.overflow_flag = (sd < -128) || (sd > 127);
      m.flags.zero_flag = (m.acc == 8'h00);
      m.flags.aux_carry_flag = int'(r.acc[3:0]) >= int'(r.mem[3:0]) + bin;
      m.flags.carry_flag = int'(r.acc) >= int'(r.mem) + bin;
    end
    if (r.op == SSB_OP_DSZ_MEM || r.op == SSB_OP_DSZ_ACC) begin
      m.acc_we = (r.op == SSB_OP_DSZ_ACC);
      m.mem_we = ~m.acc_we;
      m.acc = r.mem - 8'h01;
      m.mem = m.acc;
      m.skip = (m.acc == 8'h00);
    end
    if (r.op == SSB_OP_SET) begin
      m.mem_we = 1'b1;
      m.mem = 8'hFF;
    end
    return m;
  endfunction

  // a request that lands on the busy slot is the skipped one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_res = '0;
      exp_dummy = 1'b0;
      exp_busy = 1'b0;
    end else if (ce) begin
      exp_dummy = exp_busy;
      exp_res = (exp_busy | ~req.valid) ? '0 : model(req);
      exp_busy = exp_res.skip;
    end
  end

  // ----------------------------------------
  // checking and run control
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input logic c, input logic v, input ssb_op_t op,
                      input logic [7:0] a, input logic [7:0] m,
                      input logic [3:0] f);
    @(negedge clk);
    chk({res_reg.acc_we, res_reg.mem_we, res_reg.flags_we, res_reg.skip,
         dummy_reg, busy_reg, 2'b00},
        {exp_res.acc_we, exp_res.mem_we, exp_res.flags_we, exp_res.skip,
         exp_dummy, exp_busy, 2'b00});
    if (exp_res.acc_we) chk(res_reg.acc, exp_res.acc);
    if (exp_res.mem_we) chk(res_reg.mem, exp_res.mem);
    if (exp_res.acc_we | exp_res.mem_we)
      chk({4'h0, res_reg.flags}, {4'h0, exp_res.flags});
    ce = c;
    req = {v, op, a, m, f};
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      conclude;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    step(1, 1, SSB_OP_DSZ_MEM, 8'h00, 8'h01, 4'h0);
    step(1, 1, SSB_OP_SET, 8'h00, 8'h00, 4'hF);
    step(1, 1, SSB_OP_DSZ_ACC, 8'h00, 8'h00, 4'h5);
    step(1, 1, SSB_OP_SUB_ACC, 8'h40, 8'h40, 4'h1);
    step(1, 1, SSB_OP_SUB_MEM, 8'h40, 8'h40, 4'h0);
    step(1, 1, SSB_OP_SUB_ACC, 8'h80, 8'h01, 4'h1);
    step(1, 1, SSB_OP_DSZ_ACC, 8'h00, 8'h01, 4'hA);
    step(1, 1, SSB_OP_SUB_ACC, 8'h12, 8'h34, 4'h0);
    step(1, 1, SSB_OP_SET, 8'h00, 8'h00, 4'h3);
    for (int i = 0; i < 3000; i++) begin
      lfsr = nxt(lfsr);
      step(lfsr[31:29] != 3'h0, lfsr[28], ops[lfsr[27:20] % 6],
           lfsr[7:0], lfsr[15:8], lfsr[19:16]);
    end
    @(negedge clk);
    rst = 1'b1;
    step(1, 0, SSB_OP_NONE, 8'h00, 8'h00, 4'h0);
    rst = 1'b0;
    step(1, 1, SSB_OP_DSZ_MEM, 8'h00, 8'h01, 4'h0);
    step(1, 0, SSB_OP_NONE, 8'h00, 8'h00, 4'h0);
    step(1, 0, SSB_OP_NONE, 8'h00, 8'h00, 4'h0);
    conclude;
  end
endmodule // testbench
